// File: src/term_status_defines.vh
// Contract
// - Ignore the host command word at start-up; act only on later changes.
// - Command bit 13 set sounds the continuous buzzer.
// - Command bit 12 set sounds the short intermittent buzzer.
// - Clearing command bits 13 and 12 stops the buzzer; the code keeps the long buzzer sounding while command bit 9 is set.
// - Command bit 15 set requests screen display.
// - Status bit 15 is 1 only in run mode, else 0.
// - Outside run mode no host memory is read or written; the code still writes the status word once when run mode ends.
// - Status bit 13 shows low backup battery voltage.
// - Status bit 12 sets on screen switch, clears once reported.
// - Status bit 11 sets on numeral entry, clears once reported.
// - Status bit 10 sets on string entry, clears once reported.
// - Status bit 7 is 1 while a screen print runs.
// - System menu or error screen forces status bit 7 to 0.
// - Status word is written to the host on every change.
// - Short buzzer 0.5 s on and off, long buzzer 1.0 s.
// - One buzzer sounds: continuous, then short, then long.
// - Command bit 7 rising starts a print; cleared once printing shows.
// - Command bit 11 rising clears display history, then the bit clears.
`ifndef TERM_STATUS_DEFINES_VH
`define TERM_STATUS_DEFINES_VH

`define CMD_DISPLAY      15
`define CMD_BUZ_CONT     13
`define CMD_BUZ_SHORT    12
`define CMD_HIST_CLR     11
`define CMD_BUZ_LONG     9
`define CMD_PRINT        7

`define STS_RUN          15
`define STS_BATT         13
`define STS_SCREEN       12
`define STS_NUMERAL      11
`define STS_STRING       10
`define STS_PRINT        7

`define ADDR_COMMAND     4'h0
`define ADDR_STATUS      4'h4
`define ADDR_CONTROL     4'h8
`define ADDR_FETCH       4'hc

`define CTRL_RUN         0
`define CTRL_MENU        1
`define CTRL_ERROR       2
`define CTRL_STARTED     3

`define SHORT_PERIOD_MS  500
`define LONG_PERIOD_MS   1000
`define CLOCK_HZ         20000000

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// File: src/buzzer_tone.v
`timescale 1ns/1ps
`include "term_status_defines.vh"
module buzzer_tone #(
    parameter CLK_HZ   = `CLOCK_HZ,
    parameter SHORT_MS = `SHORT_PERIOD_MS,
    parameter LONG_MS  = `LONG_PERIOD_MS
) (
    input  wire clk,
    input  wire rst,
    input  wire cont_req,
    input  wire short_req,
    input  wire long_req,
    output reg  tone
);
    localparam SHORT_CYC = CLK_HZ / 1000 * SHORT_MS;
    localparam LONG_CYC  = CLK_HZ / 1000 * LONG_MS;
    localparam [1:0] MODE_OFF   = 2'h0;
    localparam [1:0] MODE_CONT  = 2'h1;
    localparam [1:0] MODE_SHORT = 2'h2;
    localparam [1:0] MODE_LONG  = 2'h3;

    reg  [31:0] count_reg;
    reg         phase_reg;
    reg  [1:0]  mode_reg;
    wire [1:0]  mode_next;
    wire [31:0] limit;

    // Fixed priority between the three buzzer kinds.
    assign mode_next = cont_req ? MODE_CONT : short_req ? MODE_SHORT :
                       long_req ? MODE_LONG : MODE_OFF;
    assign limit = (mode_reg == MODE_SHORT) ? SHORT_CYC : LONG_CYC;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= 32'h0;
            phase_reg <= 1'b1;
            mode_reg  <= MODE_OFF;
            tone      <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            if (mode_next != mode_reg) begin
                count_reg <= 32'h0;
                phase_reg <= 1'b1;
            end else if (count_reg == limit - 32'h1) begin
                count_reg <= 32'h0;
                phase_reg <= ~phase_reg;
            end else begin
                count_reg <= count_reg + 32'h1;
            end
            tone <= (mode_reg == MODE_CONT) |
                    ((mode_reg != MODE_OFF) & phase_reg);
        end
    end
endmodule

// File: src/strobe_flag.v
`timescale 1ns/1ps
module strobe_flag (
    input  wire clk,
    input  wire rst,
    input  wire set_in,
    input  wire clr_in,
    output reg  flag
);
    // A set in the clearing cycle wins.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_in) begin
            flag <= 1'b1;
        end else if (clr_in) begin
            flag <= 1'b0;
        end
    end
endmodule

// File: src/terminal_status_control.v
`timescale 1ns/1ps
`include "term_status_defines.vh"
module terminal_status_control #(
    parameter CLK_HZ   = `CLOCK_HZ,
    parameter SHORT_MS = `SHORT_PERIOD_MS,
    parameter LONG_MS  = `LONG_PERIOD_MS
) (
    input  wire        MCLK,
    input  wire        RST,
    input  wire [3:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [3:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire        BATTERY_LOW,
    input  wire        SCREEN_SWITCHED,
    input  wire        NUMERAL_ENTERED,
    input  wire        STRING_ENTERED,
    input  wire        PRINT_KEY,
    input  wire        PRINT_DONE,
    output reg         BUZZER,
    output reg         DISPLAY_REQ,
    output reg         PRINT_START,
    output reg         HISTORY_CLEAR,
    output reg         REPORT_WRITE
);
    reg  [15:0] cmd_reg;
    reg  [15:0] held_reg;
    reg  [3:0]  ctrl_reg;
    reg         fetch_reg;
    reg         primed_reg;
    reg         printing_reg;
    reg  [15:0] reported_reg;
    reg  [15:0] status_reg;
    reg         aw_held_reg;
    reg         w_held_reg;
    reg  [3:0]  awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg  [2:0]  batt_sync_reg;
    reg  [1:0]  scr_sync_reg;
    reg  [1:0]  num_sync_reg;
    reg  [1:0]  str_sync_reg;
    reg  [2:0]  key_sync_reg;
    reg  [1:0]  done_sync_reg;
    reg         scr_d_reg;
    reg         num_d_reg;
    reg         str_d_reg;
    reg         buz_cont_reg;
    reg         buz_short_reg;
    reg         buz_long_reg;
    wire        run;
    wire        blank_print;
    wire [15:0] changed;
    wire [15:0] rising;
    wire        do_fetch;
    wire        do_write;
    wire        report_now;
    wire        scr_flag;
    wire        num_flag;
    wire        str_flag;
    wire        tone;
    wire [15:0] status_next;
    wire [31:0] cmd_merged;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    assign run         = ctrl_reg[`CTRL_RUN] & ~ctrl_reg[`CTRL_MENU];
    assign blank_print = ctrl_reg[`CTRL_MENU] | ctrl_reg[`CTRL_ERROR];
    assign do_fetch    = fetch_reg & run;
    assign changed     = cmd_reg ^ held_reg;
    assign rising      = changed & cmd_reg;
    assign cmd_merged  = merge({16'h0, cmd_reg}, wdata_reg, wstrb_reg);

    assign S_AXI_AWREADY = ~aw_held_reg & ~S_AXI_BVALID;
    assign S_AXI_WREADY  = ~w_held_reg & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign do_write      = aw_held_reg & w_held_reg & ~S_AXI_BVALID;

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= 4'h0;
            wdata_reg    <= 32'h0;
            wstrb_reg    <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `RESP_OKAY;
            cmd_reg      <= 16'h0;
            ctrl_reg     <= 4'h0;
            fetch_reg    <= 1'b0;
        end else begin
            fetch_reg <= 1'b0;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA;
                wstrb_reg  <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= `RESP_OKAY;
                if (awaddr_reg == `ADDR_COMMAND) begin
                    cmd_reg <= cmd_merged[15:0];
                end else if (awaddr_reg == `ADDR_CONTROL) begin
                    if (wstrb_reg[0]) begin
                        ctrl_reg <= wdata_reg[3:0];
                    end
                end else if (awaddr_reg == `ADDR_FETCH) begin
                    fetch_reg <= wstrb_reg[0] & wdata_reg[0];
                end else if (awaddr_reg != `ADDR_STATUS) begin
                    S_AXI_BRESP <= `RESP_SLVERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            // Self-clearing command bits drop once serviced.
            if (primed_reg && do_fetch && rising[`CMD_HIST_CLR]) begin
                cmd_reg[`CMD_HIST_CLR] <= 1'b0;
            end
            if (cmd_reg[`CMD_PRINT] && status_reg[`STS_PRINT]) begin
                cmd_reg[`CMD_PRINT] <= 1'b0;
            end
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
            S_AXI_RRESP  <= `RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= `RESP_OKAY;
            if (S_AXI_ARADDR == `ADDR_COMMAND) begin
                S_AXI_RDATA <= {16'h0, cmd_reg};
            end else if (S_AXI_ARADDR == `ADDR_STATUS) begin
                S_AXI_RDATA <= {16'h0, reported_reg};
            end else if (S_AXI_ARADDR == `ADDR_CONTROL) begin
                S_AXI_RDATA <= {28'h0, ctrl_reg};
            end else if (S_AXI_ARADDR == `ADDR_FETCH) begin
                S_AXI_RDATA <= {31'h0, primed_reg};
            end else begin
                S_AXI_RDATA <= 32'h0;
                S_AXI_RRESP <= `RESP_SLVERR;
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            batt_sync_reg <= 3'h0;
            scr_sync_reg  <= 2'h0;
            num_sync_reg  <= 2'h0;
            str_sync_reg  <= 2'h0;
            key_sync_reg  <= 3'h0;
            done_sync_reg <= 2'h0;
            scr_d_reg     <= 1'b0;
            num_d_reg     <= 1'b0;
            str_d_reg     <= 1'b0;
        end else begin
            batt_sync_reg <= {batt_sync_reg[1:0], BATTERY_LOW};
            scr_sync_reg  <= {scr_sync_reg[0], SCREEN_SWITCHED};
            num_sync_reg  <= {num_sync_reg[0], NUMERAL_ENTERED};
            str_sync_reg  <= {str_sync_reg[0], STRING_ENTERED};
            key_sync_reg  <= {key_sync_reg[1:0], PRINT_KEY};
            done_sync_reg <= {done_sync_reg[0], PRINT_DONE};
            scr_d_reg     <= scr_sync_reg[1];
            num_d_reg     <= num_sync_reg[1];
            str_d_reg     <= str_sync_reg[1];
        end
    end

    // Command fetch: first fetch after start-up only primes the copy.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            held_reg      <= 16'h0;
            primed_reg    <= 1'b0;
            buz_cont_reg  <= 1'b0;
            buz_short_reg <= 1'b0;
            buz_long_reg  <= 1'b0;
            DISPLAY_REQ   <= 1'b0;
            PRINT_START   <= 1'b0;
            HISTORY_CLEAR <= 1'b0;
            printing_reg  <= 1'b0;
        end else begin
            DISPLAY_REQ   <= 1'b0;
            PRINT_START   <= 1'b0;
            HISTORY_CLEAR <= 1'b0;
            if (do_fetch) begin
                held_reg <= cmd_reg;
                if (!primed_reg) begin
                    primed_reg <= ctrl_reg[`CTRL_STARTED];
                end else if (changed != 16'h0) begin
                    buz_cont_reg  <= cmd_reg[`CMD_BUZ_CONT];
                    buz_short_reg <= cmd_reg[`CMD_BUZ_SHORT];
                    buz_long_reg  <= cmd_reg[`CMD_BUZ_LONG];
                    DISPLAY_REQ   <= rising[`CMD_DISPLAY];
                    HISTORY_CLEAR <= rising[`CMD_HIST_CLR];
                    if (rising[`CMD_PRINT] && !printing_reg) begin
                        PRINT_START  <= 1'b1;
                        printing_reg <= 1'b1;
                    end
                end
            end
            if (key_sync_reg[1] && !key_sync_reg[2] && !printing_reg) begin
                PRINT_START  <= 1'b1;
                printing_reg <= 1'b1;
            end else if (done_sync_reg[1]) begin
                printing_reg <= 1'b0;
            end
        end
    end

    buzzer_tone #(
        .CLK_HZ   (CLK_HZ),
        .SHORT_MS (SHORT_MS),
        .LONG_MS  (LONG_MS)
    ) u_tone (
        .clk       (MCLK),
        .rst       (RST),
        .cont_req  (buz_cont_reg),
        .short_req (buz_short_reg),
        .long_req  (buz_long_reg),
        .tone      (tone)
    );

    assign report_now = REPORT_WRITE;

    strobe_flag u_scr (
        .clk    (MCLK),
        .rst    (RST),
        .set_in (scr_sync_reg[1] & ~scr_d_reg),
        .clr_in (report_now & reported_reg[`STS_SCREEN]),
        .flag   (scr_flag)
    );

    strobe_flag u_num (
        .clk    (MCLK),
        .rst    (RST),
        .set_in (num_sync_reg[1] & ~num_d_reg),
        .clr_in (report_now & reported_reg[`STS_NUMERAL]),
        .flag   (num_flag)
    );

    strobe_flag u_str (
        .clk    (MCLK),
        .rst    (RST),
        .set_in (str_sync_reg[1] & ~str_d_reg),
        .clr_in (report_now & reported_reg[`STS_STRING]),
        .flag   (str_flag)
    );

    assign status_next = {run, 1'b0, batt_sync_reg[2], scr_flag, num_flag,
                          str_flag, 2'b00,
                          printing_reg & ~blank_print,
                          7'h00};

    // Report when the live status differs from the last written one, in run mode or once on leaving it.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            status_reg   <= 16'h0;
            reported_reg <= 16'h0;
            REPORT_WRITE <= 1'b0;
            BUZZER       <= 1'b0;
        end else begin
            status_reg   <= status_next;
            BUZZER       <= tone & run;
            REPORT_WRITE <= 1'b0;
            if (!REPORT_WRITE && status_reg != reported_reg &&
                (run || reported_reg[`STS_RUN])) begin
                reported_reg <= status_reg;
                REPORT_WRITE <= 1'b1;
            end
        end
    end
endmodule

// File: verif/term_chk.sv
`timescale 1ns/1ps
module term_chk (
    input wire        MCLK,
    input wire        RST,
    input wire [3:0]  S_AXI_AWADDR,
    input wire        S_AXI_AWVALID,
    input wire        S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire        S_AXI_WVALID,
    input wire        S_AXI_WREADY,
    input wire        BATTERY_LOW,
    input wire        SCREEN_SWITCHED,
    input wire        NUMERAL_ENTERED,
    input wire        DISPLAY_REQ,
    input wire        PRINT_START,
    input wire        HISTORY_CLEAR,
    input wire        REPORT_WRITE
);
    reg       run_q;
    reg [1:0] nf;
    wire      hs = S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY;
    wire      act = DISPLAY_REQ | PRINT_START | HISTORY_CLEAR;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // Tracks run mode and the fetches taken while running.
    always @(posedge MCLK or posedge RST) begin
        if (RST) begin
            run_q <= 1'h0;
            nf    <= 2'h0;
        end else if (hs) begin
            if (S_AXI_AWADDR == 4'h8)
                run_q <= S_AXI_WDATA[0] & ~S_AXI_WDATA[1];
            if (S_AXI_AWADDR == 4'hc && S_AXI_WDATA[0] && run_q && nf != 2'h2)
                nf <= nf + 2'h1;
        end
    end
    a_disp_pulse: assert property (DISPLAY_REQ |=> !DISPLAY_REQ)
        else $error("display request too long");
    a_print_pulse: assert property (PRINT_START |=> !PRINT_START)
        else $error("print start too long");
    a_hist_pulse: assert property (HISTORY_CLEAR |=> !HISTORY_CLEAR)
        else $error("history clear too long");
    a_report_pulse: assert property (REPORT_WRITE |=> !REPORT_WRITE)
        else $error("report pulse too long");
    a_idle_quiet: assert property (!run_q |-> !act)
        else $error("action outside run mode");
    a_boot_quiet: assert property (act |-> nf == 2'h2)
        else $error("action before a changed word");
    a_screen_report: assert property (
        $rose(SCREEN_SWITCHED) && run_q |-> ##[1:12] REPORT_WRITE)
        else $error("screen switch not reported");
    a_numeral_report: assert property (
        $rose(NUMERAL_ENTERED) && run_q |-> ##[1:12] REPORT_WRITE)
        else $error("numeral entry not reported");
    a_batt_report: assert property (
        $rose(BATTERY_LOW) && run_q |-> ##[1:12] REPORT_WRITE)
        else $error("battery change not reported");
    c_disp: cover property (DISPLAY_REQ);
    c_print: cover property (PRINT_START);
    c_hist: cover property (HISTORY_CLEAR);
endmodule

bind terminal_status_control term_chk u_chk (
    .MCLK(MCLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .BATTERY_LOW(BATTERY_LOW),
    .SCREEN_SWITCHED(SCREEN_SWITCHED), .NUMERAL_ENTERED(NUMERAL_ENTERED),
    .DISPLAY_REQ(DISPLAY_REQ), .PRINT_START(PRINT_START),
    .HISTORY_CLEAR(HISTORY_CLEAR), .REPORT_WRITE(REPORT_WRITE)
);

// File: verif/print_engine.sv
`timescale 1ns/1ps
module print_engine #(
    parameter BUSY = 60
) (
    input  wire clk,
    input  wire rst,
    input  wire start,
    input  wire key,
    output reg  done
);
    localparam [7:0] B = BUSY;
    reg [7:0] cnt;
    reg       key_q;
    // A print runs for a fixed time, then done stands for three cycles.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt   <= 8'h0;
            key_q <= 1'h0;
            done  <= 1'h0;
        end else begin
            key_q <= key;
            if (start || (key && !key_q))
                cnt <= B;
            else if (cnt != 8'h0)
                cnt <= cnt - 8'h1;
            done <= (cnt != 8'h0) && (cnt < 8'h4);
        end
    end
endmodule

// File: verif/tb_terminal_status_control.sv
`timescale 1ns/1ps
module tb_terminal_status_control;
    reg         MCLK = 1'h0;
    reg         RST = 1'h1;
    reg  [3:0]  awaddr = 4'h0;
    reg  [3:0]  araddr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    reg         arvalid = 1'h0, rready = 1'h0, batt = 1'h0, key = 1'h0;
    reg  [2:0]  ev = 3'h0;
    wire        awready, wready, bvalid, arready, rvalid, done;
    wire        buzz, disp, pst, hist, rep;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    reg  [31:0] exp_q[$];
    reg  [31:0] r;
    int         err_total = 0, n_tests = 0, cyc = 0, i, n, r0;
    int         n_disp = 0, n_pst = 0, n_hist = 0, n_rep = 0;
    int         cw[3] = '{32'h1000, 32'h0200, 32'h1200};
    int         hl[3] = '{20, 40, 20};

    terminal_status_control #(.CLK_HZ(20000), .SHORT_MS(1), .LONG_MS(2)) dut (
        .MCLK(MCLK), .RST(RST), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .BATTERY_LOW(batt),
        .SCREEN_SWITCHED(ev[2]), .NUMERAL_ENTERED(ev[1]),
        .STRING_ENTERED(ev[0]), .PRINT_KEY(key), .PRINT_DONE(done),
        .BUZZER(buzz), .DISPLAY_REQ(disp), .PRINT_START(pst),
        .HISTORY_CLEAR(hist), .REPORT_WRITE(rep)
    );
    print_engine #(.BUSY(60)) printer (
        .clk(MCLK), .rst(RST), .start(pst), .key(key), .done(done)
    );

    initial forever #25 MCLK = ~MCLK;

    task conclude;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input [31:0] s, input [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Counts output pulses and compares read data in issue order.
    always @(posedge MCLK) begin
        cyc++;
        n_disp += (disp === 1'h1);
        n_pst += (pst === 1'h1);
        n_hist += (hist === 1'h1);
        n_rep += (rep === 1'h1);
        if (rvalid === 1'h1 && rready === 1'h1) begin
            chk("rdata", rdata, exp_q.pop_front());
            chk("rresp", rresp, 32'h0);
        end
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    task tick(input int k);
        repeat (k) @(posedge MCLK);
    endtask

    task wr(input [3:0] a, input [31:0] d);
        bit pa, pw;
        pa = 1;
        pw = 1;
        @(posedge MCLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (pa || pw) begin
            @(posedge MCLK);
            if (awready === 1'h1)
                pa = 0;
            if (wready === 1'h1)
                pw = 0;
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(posedge MCLK); while (bvalid !== 1'h1);
        chk("bresp", bresp, 32'h0);
        bready <= 1'h0;
    endtask

    task rd(input [3:0] a, input [31:0] e);
        exp_q.push_back(e);
        @(posedge MCLK);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge MCLK); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge MCLK); while (rvalid !== 1'h1);
        rready <= 1'h0;
    endtask

    task cmd(input [31:0] c);
        wr(4'h0, c);
        wr(4'hc, 32'h1);
        tick(6);
    endtask

    task waitv(input logic v, output int k);
        k = 0;
        while (buzz !== v && k < 300) begin
            @(posedge MCLK);
            k++;
        end
    endtask

    task per(input int e);
        waitv(1'h0, n);
        waitv(1'h1, n);
        waitv(1'h0, n);
        chk("on", n, e);
        waitv(1'h1, n);
        chk("off", n, e);
    endtask

    initial begin
        void'($urandom(32'hbc05));
        tick(16);
        RST <= 1'h0;
        rd(4'h4, 32'h0);
        wr(4'h8, 32'h9);
        tick(8);
        rd(4'h4, 32'h8000);
        r = $urandom & 32'hffff457f;
        wr(4'h0, r);
        rd(4'h0, r & 32'h457f);
        cmd(32'ha000);
        chk("disp", n_disp, 0);
        chk("buzz", buzz, 0);
        cmd(32'h0);
        cmd(32'ha000);
        chk("disp", n_disp, 1);
        chk("buzz", buzz, 1);
        cmd(32'h3000);
        tick(30);
        chk("buzz", buzz, 1);
        for (i = 0; i < 3; i++) begin
            cmd(cw[i]);
            per(hl[i]);
        end
        cmd(32'h0);
        tick(45);
        chk("buzz", buzz, 0);
        cmd(32'h0800);
        chk("hist", n_hist, 1);
        rd(4'h0, 32'h0);
        cmd(32'h8000);
        cmd(32'h8000);
        cmd(32'h0);
        cmd(32'h8000);
        chk("disp", n_disp, 3);
        cmd(32'h0080);
        chk("pst", n_pst, 1);
        rd(4'h4, 32'h8080);
        rd(4'h0, 32'h0);
        tick(80);
        rd(4'h4, 32'h8000);
        key <= 1'h1;
        tick(10);
        wr(4'h8, 32'hd);
        tick(8);
        rd(4'h4, 32'h8000);
        wr(4'h8, 32'hb);
        tick(8);
        rd(4'h4, 32'h0);
        key <= 1'h0;
        wr(4'h8, 32'h8);
        cmd(32'h0800);
        chk("hist", n_hist, 1);
        wr(4'h8, 32'h9);
        tick(80);
        batt <= 1'h1;
        tick(12);
        rd(4'h4, 32'ha000);
        for (i = 0; i < 3; i++) begin
            r0 = n_rep;
            ev <= 3'h4 >> i;
            tick(3 + $urandom % 4);
            ev <= 3'h0;
            tick(20);
            chk("reports", n_rep - r0, 2);
        end
        rd(4'h4, 32'ha000);
        conclude();
    end
endmodule
